// [tmr_top.sv]
// 16-bit timer register slice: counter, two compare channels, byte access.
// Assumes a CPU I/O port with one-cycle read and write strobes on clock.
`timescale 1ns/100ps
`include "tmr_consts.svh"
module tmr_top (
    input wire logic clock,
    input wire logic rst,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_we,
    input wire logic io_re,
    output logic [7:0] io_rdata,
    input wire tmr_pkg::tmr_cs_e clock_source_select,
    input wire tmr_pkg::tmr_wgm_t waveform_mode_select,
    input wire tmr_pkg::tmr_act_e compare_output_action_a,
    input wire tmr_pkg::tmr_act_e compare_output_action_b,
    input wire logic external_count_pin,
    input wire logic match_flag_a_clear,
    input wire logic match_flag_b_clear,
    output logic match_flag_a,
    output logic match_flag_b,
    output logic wave_out_a,
    output logic wave_out_a_en,
    output logic wave_out_b,
    output logic wave_out_b_en,
    output logic [15:0] counter_value
);
    import tmr_pkg::*;

    logic tick;
    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] compare_value_a_q;
    logic [15:0] compare_value_b_q;
    logic [7:0] temp_q;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic block_q;
    logic non_pwm;
    logic ctc_a;
    logic eq_a;
    logic eq_b;
    logic hit_a;
    logic hit_b;
    logic force_a;
    logic force_b;
    logic wr_cnt_lo;
    logic wr_cmp_a_lo;
    logic wr_cmp_b_lo;
    logic wr_any_hi;
    logic rd_any_lo;

    // Timer clock enable from the prescaler or the count pin
    tmr_prescaler u_pre (
        .clock(clock),
        .rst(rst),
        .clock_source_select(clock_source_select),
        .external_count_pin(external_count_pin),
        .tick(tick)
    );

    // Write decode and low-byte read decode for the byte locations
    assign wr_cnt_lo = io_we && (io_addr == `TMR_ADDR_CNT_LO);
    assign wr_cmp_a_lo = io_we && (io_addr == `TMR_ADDR_CMP_A_LO);
    assign wr_cmp_b_lo = io_we && (io_addr == `TMR_ADDR_CMP_B_LO);
    assign wr_any_hi = io_we && ((io_addr == `TMR_ADDR_CNT_HI) ||
        (io_addr == `TMR_ADDR_CMP_A_HI) || (io_addr == `TMR_ADDR_CMP_B_HI));
    assign rd_any_lo = io_re && ((io_addr == `TMR_ADDR_CNT_LO) ||
        (io_addr == `TMR_ADDR_CMP_A_LO) || (io_addr == `TMR_ADDR_CMP_B_LO));

    // Force strobes live only for the write cycle, nothing is stored
    assign force_a = io_we && (io_addr == `TMR_ADDR_FORCE) &&
        io_wdata[`TMR_FORCE_A_BIT];
    assign force_b = io_we && (io_addr == `TMR_ADDR_FORCE) &&
        io_wdata[`TMR_FORCE_B_BIT];

    // Mode classification
    assign non_pwm = (waveform_mode_select == `TMR_WGM_NORMAL) ||
        (waveform_mode_select == `TMR_WGM_CTC_A) ||
        (waveform_mode_select == `TMR_WGM_CTC_ICR);
    assign ctc_a = waveform_mode_select == `TMR_WGM_CTC_A;

    // Continuous comparators
    assign eq_a = count_q == compare_value_a_q;
    assign eq_b = count_q == compare_value_b_q;

    // A match counts on a timer tick unless a counter write blocks it
    assign hit_a = tick && eq_a && !block_q;
    assign hit_b = tick && eq_b && !block_q;

    // Shared high-byte latch: loaded by high writes and low reads
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            temp_q <= `TMR_RESET_BYTE;
        end else if (wr_any_hi) begin
            temp_q <= io_wdata;
        end else if (rd_any_lo) begin
            if (io_addr == `TMR_ADDR_CNT_LO) begin
                temp_q <= count_q[15:8];
            end else if (io_addr == `TMR_ADDR_CMP_A_LO) begin
                temp_q <= compare_value_a_q[15:8];
            end else begin
                temp_q <= compare_value_b_q[15:8];
            end
        end
    end

    // Next counter value: CPU write wins over counting
    always_comb begin
        count_d = count_q;
        if (wr_cnt_lo) begin
            count_d = {temp_q, io_wdata};
        end else if (tick) begin
            if (ctc_a && hit_a) begin
                count_d = `TMR_RESET_WORD; // Forced match never gets here
            end else begin
                count_d = count_q + 16'h0001;
            end
        end
    end

    // Counter register
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_q <= `TMR_RESET_WORD;
        end else begin
            count_q <= count_d;
        end
    end

    // Match blocking after a counter write, released by the next tick
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            block_q <= 1'b0;
        end else if (wr_cnt_lo) begin
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
        end
    end

    // Compare registers commit both bytes at once
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            compare_value_a_q <= `TMR_RESET_WORD;
            compare_value_b_q <= `TMR_RESET_WORD;
        end else begin
            if (wr_cmp_a_lo) begin
                compare_value_a_q <= {temp_q, io_wdata};
            end
            if (wr_cmp_b_lo) begin
                compare_value_b_q <= {temp_q, io_wdata};
            end
        end
    end

    // Read multiplexer: high locations return the latch
    always_comb begin
        rdata_d = `TMR_RESET_BYTE;
        if (io_addr == `TMR_ADDR_CNT_LO) begin
            rdata_d = count_q[7:0];
        end else if (io_addr == `TMR_ADDR_CMP_A_LO) begin
            rdata_d = compare_value_a_q[7:0];
        end else if (io_addr == `TMR_ADDR_CMP_B_LO) begin
            rdata_d = compare_value_b_q[7:0];
        end else if ((io_addr == `TMR_ADDR_CNT_HI) ||
            (io_addr == `TMR_ADDR_CMP_A_HI) ||
            (io_addr == `TMR_ADDR_CMP_B_HI)) begin
            rdata_d = temp_q;
        end else if (io_addr == `TMR_ADDR_FORCE) begin
            rdata_d = `TMR_RESET_BYTE;
        end
    end

    // Registered read data, held until the next read
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_q <= `TMR_RESET_BYTE;
        end else if (io_re) begin
            rdata_q <= rdata_d;
        end
    end

    // Channel A
    tmr_wave_chan u_chan_a (
        .clock(clock),
        .rst(rst),
        .hit(hit_a),
        .force_strobe(force_a),
        .non_pwm(non_pwm),
        .action(compare_output_action_a),
        .flag_clear(match_flag_a_clear),
        .wave_out(wave_out_a),
        .wave_out_en(wave_out_a_en),
        .match_flag(match_flag_a)
    );

    // Channel B
    tmr_wave_chan u_chan_b (
        .clock(clock),
        .rst(rst),
        .hit(hit_b),
        .force_strobe(force_b),
        .non_pwm(non_pwm),
        .action(compare_output_action_b),
        .flag_clear(match_flag_b_clear),
        .wave_out(wave_out_b),
        .wave_out_en(wave_out_b_en),
        .match_flag(match_flag_b)
    );

    assign io_rdata = rdata_q;
    assign counter_value = count_q;
endmodule

// [tmr_consts.svh]
// Constants for the 16-bit timer register slice: offsets, fields, resets.
// Assumes an 8-bit I/O bus with 6-bit addresses on the CPU side.
`ifndef TMR_CONSTS_SVH
`define TMR_CONSTS_SVH

// Register offsets on the I/O bus
`define TMR_ADDR_CMP_B_LO 6'h24
`define TMR_ADDR_CMP_B_HI 6'h25
`define TMR_ADDR_CMP_A_LO 6'h26
`define TMR_ADDR_CMP_A_HI 6'h27
`define TMR_ADDR_CNT_LO 6'h28
`define TMR_ADDR_CNT_HI 6'h29
`define TMR_ADDR_FORCE 6'h2c

// Field positions in the force compare control register
`define TMR_FORCE_A_BIT 7
`define TMR_FORCE_B_BIT 6

// Reset values
`define TMR_RESET_BYTE 8'h00
`define TMR_RESET_WORD 16'h0000

// Prescaler taps, as divide ratio minus one on a 10-bit counter
`define TMR_PRE_WIDTH 10
`define TMR_DIV8_MASK 10'h007
`define TMR_DIV64_MASK 10'h03f
`define TMR_DIV256_MASK 10'h0ff
`define TMR_DIV1024_MASK 10'h3ff

// Waveform mode codes that are not PWM
`define TMR_WGM_NORMAL 4'h0
`define TMR_WGM_CTC_A 4'h4
`define TMR_WGM_CTC_ICR 4'hc

`endif

// [tmr_pkg.sv]
// Types shared by the timer register slice.
// Assumes tmr_consts.svh supplies the numeric constants.
package tmr_pkg;

    // Clock source select codes
    typedef enum logic [2:0] {
        TMR_CS_STOP = 3'b000,
        TMR_CS_DIV1 = 3'b001,
        TMR_CS_DIV8 = 3'b010,
        TMR_CS_DIV64 = 3'b011,
        TMR_CS_DIV256 = 3'b100,
        TMR_CS_DIV1024 = 3'b101,
        TMR_CS_EXT_FALL = 3'b110,
        TMR_CS_EXT_RISE = 3'b111
    } tmr_cs_e;

    // Compare output action codes in non-PWM modes
    typedef enum logic [1:0] {
        TMR_ACT_OFF = 2'b00,
        TMR_ACT_TOGGLE = 2'b01,
        TMR_ACT_CLEAR = 2'b10,
        TMR_ACT_SET = 2'b11
    } tmr_act_e;

    typedef logic [3:0] tmr_wgm_t;

endpackage

// [tmr_prescaler.sv]
// Timer clock enable: prescaler taps and external count pin edges.
// Assumes external_count_pin is asynchronous to clock.
`timescale 1ns/100ps
`include "tmr_consts.svh"
module tmr_prescaler (
    input wire logic clock,
    input wire logic rst,
    input wire tmr_pkg::tmr_cs_e clock_source_select,
    input wire logic external_count_pin,
    output logic tick
);
    import tmr_pkg::*;

    logic [`TMR_PRE_WIDTH-1:0] pre_q;
    logic pin_s1_q;
    logic pin_s2_q;
    logic pin_s3_q;

    // Free running prescaler count
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // Pin synchroniser plus one stage for edge detection; the pin is
    // sampled whatever its port direction, so software may drive it
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
            pin_s3_q <= 1'b0;
        end else begin
            pin_s1_q <= external_count_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // Select the timer clock enable
    always_comb begin
        case (clock_source_select)
            TMR_CS_STOP: tick = 1'b0;
            TMR_CS_DIV1: tick = 1'b1;
            TMR_CS_DIV8: tick = (pre_q & `TMR_DIV8_MASK) == `TMR_DIV8_MASK;
            TMR_CS_DIV64: tick = (pre_q & `TMR_DIV64_MASK) == `TMR_DIV64_MASK;
            TMR_CS_DIV256: tick = (pre_q & `TMR_DIV256_MASK) == `TMR_DIV256_MASK;
            TMR_CS_DIV1024: tick = pre_q == `TMR_DIV1024_MASK;
            TMR_CS_EXT_FALL: tick = pin_s3_q & ~pin_s2_q;
            TMR_CS_EXT_RISE: tick = ~pin_s3_q & pin_s2_q;
            default: tick = 1'b0;
        endcase
    end
endmodule

// [tmr_wave_chan.sv]
// One compare channel: match flag and waveform output.
// Assumes hit is already qualified by the timer tick and write blocking.
`timescale 1ns/100ps
`include "tmr_consts.svh"
module tmr_wave_chan (
    input wire logic clock,
    input wire logic rst,
    input wire logic hit,
    input wire logic force_strobe,
    input wire logic non_pwm,
    input wire tmr_pkg::tmr_act_e action,
    input wire logic flag_clear,
    output logic wave_out,
    output logic wave_out_en,
    output logic match_flag
);
    import tmr_pkg::*;

    logic wave_q;
    logic flag_q;
    logic fire;

    // Forced compare only acts in non-PWM modes
    assign fire = hit | (force_strobe & non_pwm);

    // Output pin action on match or forced compare
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wave_q <= 1'b0;
        end else if (fire && non_pwm) begin
            case (action)
                TMR_ACT_TOGGLE: wave_q <= ~wave_q;
                TMR_ACT_CLEAR: wave_q <= 1'b0;
                TMR_ACT_SET: wave_q <= 1'b1;
                default: wave_q <= wave_q;
            endcase
        end
    end

    // Sticky match flag, set only by a real match; set beats clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (hit) begin
            flag_q <= 1'b1;
        end else if (flag_clear) begin
            flag_q <= 1'b0;
        end
    end

    assign wave_out = wave_q;
    assign wave_out_en = action != TMR_ACT_OFF;
    assign match_flag = flag_q;
endmodule

// [tmr_checker.sv]
// Checker for the timer slice: watches only the top-level ports.
// Assumes one clock domain and an asynchronous active-high reset.
`timescale 1ns/100ps
`include "tmr_consts.svh"
module tmr_checker
    import tmr_pkg::*;
(
    input wire logic clock, rst, io_we, io_re,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata, io_rdata,
    input wire tmr_cs_e clock_source_select,
    input wire tmr_wgm_t waveform_mode_select,
    input wire tmr_act_e compare_output_action_a, compare_output_action_b,
    input wire logic external_count_pin, match_flag_a_clear,
    input wire logic match_flag_b_clear, match_flag_a, match_flag_b,
    input wire logic wave_out_a, wave_out_a_en, wave_out_b, wave_out_b_en,
    input wire logic [15:0] counter_value
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Decoded strobes and mode class
    logic cnt_wr, frc_wr, non_pwm;
    assign cnt_wr = io_we && io_addr == `TMR_ADDR_CNT_LO;
    assign frc_wr = io_we && io_addr == `TMR_ADDR_FORCE;
    assign non_pwm = waveform_mode_select inside {4'h0, 4'h4, 4'hc};
    // Pin value after a forced match with the given action
    function automatic logic act_out(tmr_act_e a, logic w);
        if (a == TMR_ACT_TOGGLE) return !w;
        if (a == TMR_ACT_OFF) return w;
        return a == TMR_ACT_SET;
    endfunction
    // Long enough for the pin synchroniser to drain
    sequence stopped;
        (clock_source_select == TMR_CS_STOP) [*4];
    endsequence
    sequence run1;
        (clock_source_select == TMR_CS_DIV1) [*3];
    endsequence
    stop_hold_a: assert property (stopped ##0 !cnt_wr |=>
        $stable(counter_value)) else $error("counter moved while stopped");
    div1_step_a: assert property (run1 ##0 (!cnt_wr &&
        waveform_mode_select == 4'h0) |=>
        counter_value == $past(counter_value) + 16'h1)
        else $error("counter missed a step");
    commit_pair_a: assert property (io_we &&
        io_addr == `TMR_ADDR_CNT_HI ##1 cnt_wr |=>
        counter_value == {$past(io_wdata, 2), $past(io_wdata)})
        else $error("counter word not committed");
    low_read_a: assert property (io_re &&
        io_addr == `TMR_ADDR_CNT_LO |=>
        {8'h00, io_rdata} == ($past(counter_value) & 16'h00ff))
        else $error("low byte read wrong");
    force_zero_a: assert property (io_re &&
        io_addr == `TMR_ADDR_FORCE |=> io_rdata == 8'h00)
        else $error("force register read nonzero");
    force_act_a: assert property (stopped ##0
        (frc_wr && io_wdata[7] && non_pwm) |=> wave_out_a ==
        act_out($past(compare_output_action_a), $past(wave_out_a)))
        else $error("forced action wrong on channel a");
    force_act_b_a: assert property (stopped ##0
        (frc_wr && io_wdata[6] && non_pwm) |=> wave_out_b ==
        act_out($past(compare_output_action_b), $past(wave_out_b)))
        else $error("forced action wrong on channel b");
    pwm_ignore_a: assert property (stopped ##0
        (frc_wr && !non_pwm) |=>
        $stable(wave_out_a) && $stable(wave_out_b))
        else $error("force acted in pwm mode");
    force_noflag_a: assert property (stopped ##0
        (frc_wr && !match_flag_a && !match_flag_b) |=>
        !match_flag_a && !match_flag_b) else $error("force set a flag");
    en_follow_a: assert property (
        wave_out_a_en == (compare_output_action_a != TMR_ACT_OFF) &&
        wave_out_b_en == (compare_output_action_b != TMR_ACT_OFF))
        else $error("pin enable wrong");
    // Main scenarios reached
    cover property (stopped ##0 (frc_wr && non_pwm));
    cover property (io_we && io_addr == `TMR_ADDR_CNT_HI ##1 cnt_wr);
    cover property ($rose(match_flag_b));
endmodule
bind tmr_top tmr_checker u_tmr_checker (.clock(clock), .rst(rst),
    .io_we(io_we), .io_re(io_re), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .clock_source_select(clock_source_select),
    .waveform_mode_select(waveform_mode_select),
    .compare_output_action_a(compare_output_action_a),
    .compare_output_action_b(compare_output_action_b),
    .external_count_pin(external_count_pin),
    .match_flag_a_clear(match_flag_a_clear),
    .match_flag_b_clear(match_flag_b_clear), .match_flag_a(match_flag_a),
    .match_flag_b(match_flag_b), .wave_out_a(wave_out_a),
    .wave_out_a_en(wave_out_a_en), .wave_out_b(wave_out_b),
    .wave_out_b_en(wave_out_b_en), .counter_value(counter_value));

// [tb_top.sv]
// Self-checking bench for the timer slice with a byte-access model.
// Assumes tmr_top with its checker bound; inputs move on falling edges.
`timescale 1ns/100ps
module tb_top;
    import tmr_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic we = 1'b0;
    logic re = 1'b0;
    logic pin = 1'b0;
    logic clr = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [7:0] wdat = 8'h00;
    logic [7:0] rdat, rq;
    tmr_cs_e cs = TMR_CS_STOP;
    tmr_wgm_t wgm = 4'h0;
    tmr_act_e act_a = TMR_ACT_OFF;
    tmr_act_e act_b = TMR_ACT_OFF;
    logic fa, fb, wa, wb;
    logic [15:0] cnt, v;
    logic [15:0] mdl [int];
    logic m_wa = 1'b0;
    logic m_wb = 1'b0;
    logic [1:0] sa [5] = '{2'h2, 2'h1, 2'h3, 2'h1, 2'h0};
    logic [1:0] sb [5] = '{2'h3, 2'h1, 2'h2, 2'h1, 2'h0};
    int div [6] = '{0, 1, 8, 64, 256, 1024};
    int failures = 0;
    int compares = 0;
    int cycles = 0;
    int e;
    // Design under test
    tmr_top u_tmr_top (.clock(clock), .rst(rst), .io_addr(addr),
        .io_wdata(wdat), .io_we(we), .io_re(re), .io_rdata(rdat),
        .clock_source_select(cs), .waveform_mode_select(wgm),
        .compare_output_action_a(act_a), .compare_output_action_b(act_b),
        .external_count_pin(pin), .match_flag_a_clear(clr),
        .match_flag_b_clear(clr), .match_flag_a(fa), .match_flag_b(fb),
        .wave_out_a(wa), .wave_out_a_en(), .wave_out_b(wb),
        .wave_out_b_en(), .counter_value(cnt));
    // Clock and hang guard
    initial forever #4 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 12000) begin
            failures++;
            wrap_up();
        end
    end
    task wrap_up();
        if (failures == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [15:0] x, input logic [15:0] g);
        compares++;
        if (g !== x) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask
    // One bus cycle; returns the data of the previous read
    task step(input logic [1:0] op, input logic [5:0] a, input logic [7:0] d);
        @(negedge clock);
        rq = rdat;
        we = op[1];
        re = op[0];
        addr = a;
        wdat = d;
    endtask
    task wr16(input logic [5:0] lo, input logic [15:0] d);
        step(2'b10, lo + 6'h1, d[15:8]);
        step(2'b10, lo, d[7:0]);
        step(2'b00, lo, 8'h00);
        mdl[lo] = d;
    endtask
    task rd16(input logic [5:0] lo, output logic [15:0] q);
        step(2'b01, lo, 8'h00);
        step(2'b01, lo + 6'h1, 8'h00);
        q[7:0] = rq;
        step(2'b00, lo, 8'h00);
        q[15:8] = rq;
    endtask
    function automatic logic fm(input tmr_act_e a, input logic w);
        if (a == TMR_ACT_TOGGLE) return ~w;
        if (a == TMR_ACT_OFF) return w;
        return a == TMR_ACT_SET;
    endfunction
    // Main sequence
    initial begin
        void'($urandom(95938));
        repeat (10) @(posedge clock);
        @(negedge clock);
        rst = 1'b0;
        for (int a = 'h24; a < 'h2a; a += 2) begin
            mdl[a] = 16'h0000;
            rd16(6'(a), v);
            chk("reset word", 16'h0000, v);
        end
        chk("reset pins", 16'h0000, {12'h000, fa, fb, wa, wb});
        step(2'b10, 6'h2c, 8'hff);
        step(2'b01, 6'h2c, 8'h00);
        step(2'b01, 6'h2a, 8'h00);
        chk("force read", 16'h0000, {8'h00, rq});
        step(2'b00, 6'h2a, 8'h00);
        chk("unmapped read", 16'h0000, {8'h00, rq});
        repeat (6) begin
            e = 'h24 + 2 * $urandom_range(2);
            wr16(6'(e), 16'($urandom));
            rd16(6'(e), v);
            chk("word", mdl[e], v);
            chk("live count", mdl['h28], cnt);
        end
        step(2'b10, 6'h27, 8'h5a);
        step(2'b10, 6'h28, 8'h3c);
        step(2'b00, 6'h28, 8'h00);
        chk("shared latch", 16'h5a3c, cnt);
        for (int c = 0; c < 6; c++) begin
            wr16(6'h28, 16'h0000); // Written while stopped
            cs = tmr_cs_e'(c);
            repeat (c == 0 ? 40 : 3 * div[c]) @(negedge clock);
            cs = TMR_CS_STOP;
            repeat (4) @(negedge clock);
            e = c == 0 ? 0 : 3;
            v = (cnt + 1 >= e && cnt <= e + 1) ? 16'(e) : cnt;
            chk("rate", 16'(e), v);
        end
        for (int c = 6; c < 8; c++) begin
            wr16(6'h28, 16'h0000);
            cs = tmr_cs_e'(c);
            repeat (6) @(negedge clock);
            pin = 1'b1;
            repeat (6) @(negedge clock);
            chk("pin rise", 16'(c - 6), cnt);
            pin = 1'b0;
            repeat (6) @(negedge clock);
            chk("pin fall", 16'h0001, cnt);
            cs = TMR_CS_STOP;
        end
        // Forced matches while stopped, every action code
        clr = 1'b1;
        @(negedge clock);
        clr = 1'b0;
        for (int i = 0; i < 5; i++) begin
            act_a = tmr_act_e'(sa[i]);
            act_b = tmr_act_e'(sb[i]);
            step(2'b10, 6'h2c, 8'hc0);
            step(2'b00, 6'h2c, 8'h00);
            m_wa = fm(act_a, m_wa);
            m_wb = fm(act_b, m_wb);
            chk("force out", {14'h0, m_wa, m_wb}, {14'h0, wa, wb});
            chk("force flag", 16'h0000, {14'h0, fa, fb});
        end
        wgm = 4'(5 + $urandom_range(6));
        act_a = TMR_ACT_TOGGLE;
        step(2'b10, 6'h2c, 8'h80);
        step(2'b00, 6'h2c, 8'h00);
        chk("pwm force", {15'h0, m_wa}, {15'h0, wa});
        wgm = 4'h4;
        step(2'b10, 6'h2c, 8'h80);
        step(2'b00, 6'h2c, 8'h00);
        m_wa = ~m_wa;
        chk("ctc force", {m_wa, 15'h0001}, {wa, cnt[14:0]});
        // Counter write blocks the next match; later match still lands
        wgm = 4'h0;
        act_a = TMR_ACT_CLEAR;
        act_b = TMR_ACT_TOGGLE;
        wr16(6'h26, 16'h0005);
        wr16(6'h24, 16'h0007);
        wr16(6'h28, 16'h0100);
        cs = TMR_CS_DIV1;
        wr16(6'h28, 16'h0005);
        repeat (4) @(negedge clock);
        cs = TMR_CS_STOP;
        repeat (4) @(negedge clock);
        chk("blocked match", {14'h0, m_wa, 1'b0}, {14'h0, wa, fa});
        m_wb = ~m_wb;
        chk("match b", {14'h0, m_wb, 1'b1}, {14'h0, wb, fb});
        clr = 1'b1;
        @(negedge clock);
        clr = 1'b0;
        chk("flag clear", 16'h0000, {14'h0, fa, fb});
        wgm = 4'h4;
        cs = TMR_CS_DIV1;
        wr16(6'h28, 16'h0000);
        repeat (30) @(negedge clock);
        cs = TMR_CS_STOP;
        repeat (4) @(negedge clock);
        chk("ctc wrap", 16'h0001, {15'h0, cnt <= 16'h0005});
        chk("ctc match", 16'h0001, {14'h0, wa, fa});
        wrap_up();
    end
endmodule
